// [dv/ocfr_fault_ctrl_tb.sv]
// self-checking bench of the over-current fault response block
`timescale 1ns/100ps
`default_nettype none
module ocfr_fault_ctrl_tb;
	logic        sys_clk;
	logic        rst;
	logic        oc_detect;
	logic        uv_below;
	logic        ctrl_on;
	logic        other_fault;
	logic [15:0] unit_cycles;
	logic        scl;
	logic        sda_drv;
	logic        sda_out;
	logic        sda_oe_n;
	wire logic   sda_line;
	logic        output_en;
	logic        cc_limit;
	logic        oc_status;
	logic        alert_n;
	logic [15:0] oc_limit;
	logic [15:0] rd;
	logic        nak;
	logic        en_q;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          rises = 0;
	int          base;

	// pull-up: high unless some party pulls low
	assign sda_line = sda_drv & (sda_oe_n | sda_out);

	ocfr_fault_ctrl u_dut (
		.sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .oc_detect(oc_detect),
		.uv_below(uv_below), .ctrl_on(ctrl_on), .other_fault(other_fault),
		.unit_cycles(unit_cycles), .output_en(output_en), .cc_limit(cc_limit),
		.oc_status(oc_status), .alert_n(alert_n), .oc_limit(oc_limit)
	);
	ocfr_host_model u_host (
		.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
	);

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// restart counter and hang limit
	// ----------------------------------------
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		en_q <= output_en;
		if (output_en === 1'h1 && en_q === 1'h0) begin
			rises <= rises + 1;
		end
		if (cyc == 90000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		if (err_total == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wait_n

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk1(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk1

	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_rng

	task automatic bus(input logic [7:0] c, input int nw, input logic [15:0] w,
		input int nr, input logic exp_nak);
		u_host.xact(c, nw, w, nr, rd, nak);
		chk1("nak", exp_nak, nak);
	endtask : bus

	task automatic set_resp(input logic [1:0] m, input logic [2:0] r, input logic [2:0] d);
		bus(ocfr_pkg::CMD_RESP, 1, {8'h00, m, r, d}, 0, 1'h0);
	endtask : set_resp

	// ctrl off then on ends the fault episode and clears the status
	task automatic recycle;
		oc_detect <= 1'h0;
		other_fault <= 1'h0;
		ctrl_on <= 1'h0;
		wait_n(10);
		chk1("output_en off", 1'h0, output_en);
		ctrl_on <= 1'h1;
		wait_n(30);
		chk1("output_en on", 1'h1, output_en);
		chk1("oc_status", 1'h0, oc_status);
		chk1("alert_n", 1'h1, alert_n);
	endtask : recycle

	// limiting time from cc_limit rise to shutdown is unit * 2^delay
	task automatic lim_time(input logic [15:0] u, input logic [2:0] d);
		int n;
		unit_cycles <= u;
		set_resp(ocfr_pkg::MODE_DELAY, ocfr_pkg::RETRY_NONE, d);
		oc_detect <= 1'h1;
		n = 0;
		while (cc_limit !== 1'h1 && n < 50) begin
			wait_n(1);
			n++;
		end
		n = 0;
		while (output_en === 1'h1 && n < 400) begin
			wait_n(1);
			n++;
		end
		chk_rng("limit time", u * (1 << d) - 1, u * (1 << d) + 2, n);
		recycle();
	endtask : lim_time

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'h1;
		oc_detect = 1'h0;
		uv_below = 1'h0;
		ctrl_on = 1'h1;
		other_fault = 1'h0;
		unit_cycles = 16'h0004;
		wait_n(20);
		rst <= 1'h0;
		wait_n(10);
		chk1("output_en", 1'h1, output_en);
		bus(ocfr_pkg::CMD_LIMIT, 0, 16'h0000, 2, 1'h0);
		chk("limit reset", ocfr_pkg::LIMIT_RST, rd);
		bus(ocfr_pkg::CMD_RESP, 0, 16'h0000, 1, 1'h0);
		chk("resp reset", {8'h00, ocfr_pkg::RESP_RST}, rd);
		bus(ocfr_pkg::CMD_LIMIT, 2, 16'hbe5a, 0, 1'h0);
		wait_n(4);
		chk("oc_limit", 16'hbe5a, oc_limit);
		bus(ocfr_pkg::CMD_LIMIT, 0, 16'h0000, 2, 1'h0);
		chk("limit", 16'hbe5a, rd);
		u_host.extra = 12;
		bus(ocfr_pkg::CMD_RESP, 1, 16'h009a, 0, 1'h0);
		u_host.extra = 0;
		bus(ocfr_pkg::CMD_RESP, 0, 16'h0000, 1, 1'h0);
		chk("resp", 16'h009a, rd);
		bus(8'h55, 0, 16'h0000, 1, 1'h1);
		chk("unknown read", {8'h00, ocfr_pkg::RD_IDLE_BYTE}, rd);
		set_resp(ocfr_pkg::MODE_IGNORE, ocfr_pkg::RETRY_NONE, 3'h0);
		oc_detect <= 1'h1;
		uv_below <= 1'h1;
		wait_n(300);
		chk1("cc_limit", 1'h1, cc_limit);
		chk1("output_en", 1'h1, output_en);
		chk1("oc_status", 1'h1, oc_status);
		chk1("alert_n", 1'h0, alert_n);
		recycle();
		set_resp(ocfr_pkg::MODE_COND, ocfr_pkg::RETRY_NONE, 3'h0);
		uv_below <= 1'h0;
		oc_detect <= 1'h1;
		wait_n(100);
		chk1("cc_limit", 1'h1, cc_limit);
		chk1("output_en", 1'h1, output_en);
		uv_below <= 1'h1;
		wait_n(300);
		chk1("output_en", 1'h0, output_en);
		oc_detect <= 1'h0;
		uv_below <= 1'h0;
		wait_n(10);
		bus(ocfr_pkg::CMD_CLEAR, 0, 16'h0000, 0, 1'h0);
		wait_n(30);
		chk1("output_en", 1'h1, output_en);
		chk1("oc_status", 1'h0, oc_status);
		lim_time(16'h0004, 3'h0);
		lim_time(16'h0006, 3'h3);
		lim_time(16'h0001, 3'h7);
		unit_cycles <= 16'h0004;
		for (int r = 0; r < 8; r++) begin
			set_resp(ocfr_pkg::MODE_OFF, r[2:0], 3'h0);
			base = rises;
			oc_detect <= 1'h1;
			wait_n(600);
			chk_rng("restarts", (r == 7) ? 8 : r, (r == 7) ? 1000 : r, rises - base);
			chk1("oc_status", 1'h1, oc_status);
			if (r == 7) begin
				base = rises;
				other_fault <= 1'h1;
				wait_n(300);
				chk_rng("restarts after other fault", 0, 1, rises - base);
			end else begin
				chk1("output_en latched", 1'h0, output_en);
			end
			recycle();
		end
		tally_and_finish();
	end
endmodule : ocfr_fault_ctrl_tb
`default_nettype wire

// [dv/ocfr_host_model.sv]
// serial bus host model that drives the block's register port
`timescale 1ns/100ps
`default_nettype none
module ocfr_host_model #(
	parameter logic [6:0] DEV_ADDR = ocfr_pkg::DEV_ADDR_DEF
) (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output var  logic scl,
	output var  logic sda_drv
);
	// extra low-phase cycles, so the bus can also run slowly
	int extra = 0;

	initial begin
		scl = 1'h1;
		sda_drv = 1'h1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	// ----------------------------------------
	// bit level: 160 ns per bit, clock idles high between frames
	// ----------------------------------------
	task automatic bit_io(input logic b, output logic s);
		sda_drv <= b;
		tick(4 + extra);
		scl <= 1'h1;
		tick(4);
		s = sda_line;
		tick(4);
		scl <= 1'h0;
		tick(4);
	endtask : bit_io

	task automatic start_cond;
		sda_drv <= 1'h1;
		tick(4);
		scl <= 1'h1;
		tick(4);
		sda_drv <= 1'h0;
		tick(4);
		scl <= 1'h0;
		tick(4);
	endtask : start_cond

	task automatic stop_cond;
		sda_drv <= 1'h0;
		tick(4);
		scl <= 1'h1;
		tick(4);
		sda_drv <= 1'h1;
		tick(8);
	endtask : stop_cond

	// released data reads back high through the pull-up
	task automatic byte_io(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], s);
			rx[i] = s;
		end
		bit_io(ack_in, ack);
	endtask : byte_io

	// ----------------------------------------
	// transfer: write bytes low first, optional read after repeated start
	// ----------------------------------------
	task automatic xact(input logic [7:0] cmd, input int n_wr, input logic [15:0] wd,
		input int n_rd, output logic [15:0] rd, output logic nak);
		logic [7:0] b;
		logic       a;
		nak = 1'h0;
		rd = 16'h0000;
		start_cond();
		byte_io({DEV_ADDR, 1'h0}, 1'h1, b, a);
		nak |= a;
		byte_io(cmd, 1'h1, b, a);
		nak |= a;
		for (int i = 0; i < n_wr; i++) begin
			byte_io(wd[8*i +: 8], 1'h1, b, a);
			nak |= a;
		end
		if (n_rd > 0) begin
			start_cond();
			byte_io({DEV_ADDR, 1'h1}, 1'h1, b, a);
			nak |= a;
			for (int i = 0; i < n_rd; i++) begin
				byte_io(8'hff, (i == n_rd - 1), b, a);
				rd[8*i +: 8] = b;
			end
		end
		stop_cond();
	endtask : xact
endmodule : ocfr_host_model
`default_nettype wire

// [hw/ocfr_delay_timer.sv]
// delay timer: unit length times a power-of-two count of units
`timescale 1ns/100ps
`default_nettype none
module ocfr_delay_timer #(
	parameter int UNIT_W = 16
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire logic [2:0]        exp_sel,
	input  wire logic [UNIT_W-1:0] unit_cycles,
	output var  logic              done
);
	localparam logic [7:0] ONE8 = 8'h01;
	localparam logic [UNIT_W-1:0] ONEU = UNIT_W'(1);

	logic [UNIT_W-1:0] pre;
	logic [7:0]        units;
	logic              run;
	logic [7:0]        last_unit;
	logic [UNIT_W-1:0] last_pre;

	assign last_unit = (ONE8 << exp_sel) - ONE8;
	// a zero unit length is treated as one cycle so the timer always ends
	assign last_pre  = (unit_cycles == '0) ? '0 : unit_cycles - ONEU;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre   <= '0;
			units <= 8'h00;
			run   <= 1'b0;
			done  <= 1'b0;
		end else if (start) begin
			pre   <= '0;
			units <= 8'h00;
			run   <= 1'b1;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (run) begin
				if (pre == last_pre) begin
					pre <= '0;
					if (units == last_unit) begin
						run  <= 1'b0;
						done <= 1'b1;
					end else begin
						units <= units + ONE8;
					end
				end else begin
					pre <= pre + ONEU;
				end
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [31:0] elapsed;
	logic [31:0] expect_len;

	assign expect_len = 32'((unit_cycles == '0) ? ONEU : unit_cycles) << exp_sel;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			elapsed <= 32'h0;
		end else if (start) begin
			elapsed <= 32'h0;
		end else if (run) begin
			elapsed <= elapsed + 32'h1;
		end
	end

	property p_delay_len;
		@(posedge sys_clk) disable iff (rst)
		done |-> (elapsed == expect_len);
	endproperty
	a_delay_len: assert property (p_delay_len)
		else $error("delay length differs from unit times power of two");
endmodule : ocfr_delay_timer
`default_nettype wire

// [hw/ocfr_fault_ctrl.sv]
// over-current fault response with its serial register port
`timescale 1ns/100ps
`default_nettype none
module ocfr_fault_ctrl #(
	parameter logic [6:0] DEV_ADDR = ocfr_pkg::DEV_ADDR_DEF,
	parameter int         UNIT_W   = 16
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              scl,
	input  wire logic              sda_in,
	output var  logic              sda_out,
	output var  logic              sda_oe_n,
	input  wire logic              oc_detect,
	input  wire logic              uv_below,
	input  wire logic              ctrl_on,
	input  wire logic              other_fault,
	input  wire logic [UNIT_W-1:0] unit_cycles,
	output var  logic              output_en,
	output var  logic              cc_limit,
	output var  logic              oc_status,
	output var  logic              alert_n,
	output var  logic [15:0]       oc_limit
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	ocfr_pkg::ocfr_pins_t sync1, pin, pin_d;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1 <= '0;
			pin   <= '0;
			pin_d <= '0;
		end else begin
			sync1 <= {ctrl_on, uv_below, oc_detect, sda_in, scl};
			pin   <= sync1;
			pin_d <= pin;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, oc_rise;
	assign scl_rise  = pin.scl & ~pin_d.scl;
	assign scl_fall  = ~pin.scl & pin_d.scl;
	assign bus_start = pin.scl & pin_d.scl & pin_d.sda & ~pin.sda;
	assign bus_stop  = pin.scl & pin_d.scl & ~pin_d.sda & pin.sda;
	assign oc_rise   = pin.oc & ~pin_d.oc;

	// ----------------------------------------
	// serial register port
	// ----------------------------------------
	ocfr_pkg::ocfr_phase_t ph;
	ocfr_pkg::ocfr_resp_t  resp;
	logic [7:0]  sh, cmd, txd, rd_lo, rd_hi;
	logic [15:0] wbuf;
	logic [3:0]  bitcnt;
	logic [1:0]  nbytes;
	logic        is_read, mack, wr_limit, wr_resp, clr_pulse, cmd_known;

	assign cmd_known = (sh == ocfr_pkg::CMD_LIMIT) || (sh == ocfr_pkg::CMD_RESP) ||
		(sh == ocfr_pkg::CMD_CLEAR);
	assign rd_lo = (cmd == ocfr_pkg::CMD_LIMIT) ? oc_limit[7:0] :
		(cmd == ocfr_pkg::CMD_RESP) ? resp : ocfr_pkg::RD_IDLE_BYTE;
	assign rd_hi = (cmd == ocfr_pkg::CMD_LIMIT) ? oc_limit[15:8] : rd_lo;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ph        <= ocfr_pkg::PH_IDLE;
			sh        <= 8'h00;
			cmd       <= 8'h00;
			txd       <= 8'h00;
			wbuf      <= 16'h0000;
			bitcnt    <= 4'h0;
			nbytes    <= 2'h0;
			is_read   <= 1'b0;
			mack      <= 1'b0;
			sda_oe_n  <= 1'b1;
			sda_out   <= 1'b0;
			wr_limit  <= 1'b0;
			wr_resp   <= 1'b0;
			clr_pulse <= 1'b0;
		end else begin
			wr_limit  <= 1'b0;
			wr_resp   <= 1'b0;
			clr_pulse <= 1'b0;
			if (bus_start) begin
				ph       <= ocfr_pkg::PH_ADDR;
				bitcnt   <= 4'h0;
				nbytes   <= 2'h0;
				sda_oe_n <= 1'b1;
			end else if (bus_stop) begin
				ph       <= ocfr_pkg::PH_IDLE;
				sda_oe_n <= 1'b1;
				// a write takes effect only when complete at the stop
				if (!is_read) begin
					wr_limit  <= (cmd == ocfr_pkg::CMD_LIMIT) && (nbytes == ocfr_pkg::NB_WORD);
					wr_resp   <= (cmd == ocfr_pkg::CMD_RESP) && (nbytes == ocfr_pkg::NB_BYTE);
					clr_pulse <= (cmd == ocfr_pkg::CMD_CLEAR) && (nbytes == ocfr_pkg::NB_CMD_ONLY);
				end
			end else if (scl_rise) begin
				if (ph == ocfr_pkg::PH_ADDR || ph == ocfr_pkg::PH_WR) begin
					sh     <= {sh[6:0], pin.sda};
					bitcnt <= bitcnt + 4'h1;
				end else if (ph == ocfr_pkg::PH_RD) begin
					bitcnt <= bitcnt + 4'h1;
				end else if (ph == ocfr_pkg::PH_RACK) begin
					mack <= ~pin.sda;
				end
			end else if (scl_fall) begin
				unique case (ph)
					ocfr_pkg::PH_IDLE: ;
					ocfr_pkg::PH_ADDR: if (bitcnt == ocfr_pkg::BYTE_BITS) begin
						bitcnt <= 4'h0;
						if (sh[7:1] == DEV_ADDR) begin
							ph       <= ocfr_pkg::PH_AACK;
							sda_oe_n <= 1'b0;
							is_read  <= sh[0];
							txd      <= rd_lo;
						end else begin
							ph <= ocfr_pkg::PH_IDLE;
						end
					end
					ocfr_pkg::PH_AACK: begin
						bitcnt <= 4'h0;
						if (is_read) begin
							ph       <= ocfr_pkg::PH_RD;
							sda_oe_n <= txd[7];
						end else begin
							ph       <= ocfr_pkg::PH_WR;
							sda_oe_n <= 1'b1;
						end
					end
					ocfr_pkg::PH_WR: if (bitcnt == ocfr_pkg::BYTE_BITS) begin
						bitcnt <= 4'h0;
						ph     <= ocfr_pkg::PH_WACK;
						if (nbytes != ocfr_pkg::NB_WORD) begin
							nbytes <= nbytes + 2'h1;
						end
						if (nbytes == 2'h0) begin
							cmd      <= sh;
							sda_oe_n <= ~cmd_known;
						end else begin
							wbuf     <= {sh, wbuf[15:8]};
							sda_oe_n <= (nbytes == ocfr_pkg::NB_WORD);
						end
					end
					ocfr_pkg::PH_WACK: begin
						ph       <= ocfr_pkg::PH_WR;
						sda_oe_n <= 1'b1;
					end
					ocfr_pkg::PH_RD: if (bitcnt == ocfr_pkg::BYTE_BITS) begin
						ph       <= ocfr_pkg::PH_RACK;
						sda_oe_n <= 1'b1;
					end else begin
						sda_oe_n <= txd[6];
						txd      <= {txd[6:0], 1'b0};
					end
					ocfr_pkg::PH_RACK: if (mack) begin
						ph       <= ocfr_pkg::PH_RD;
						bitcnt   <= 4'h0;
						txd      <= rd_hi;
						sda_oe_n <= rd_hi[7];
					end else begin
						ph <= ocfr_pkg::PH_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			oc_limit <= ocfr_pkg::LIMIT_RST;
			resp     <= ocfr_pkg::RESP_RST;
		end else begin
			if (wr_limit) begin
				oc_limit <= wbuf;
			end
			if (wr_resp) begin
				resp <= wbuf[15:8];
			end
		end
	end

	// ----------------------------------------
	// fault response state machine
	// ----------------------------------------
	ocfr_pkg::ocfr_state_t state, next_state;
	logic [2:0] attempts;
	logic       shut, tmr_start, tmr_done, next_status;

	always_comb begin
		next_state = state;
		shut       = 1'b0;
		unique case (state)
			ocfr_pkg::ST_OFF:   if (pin.on) next_state = ocfr_pkg::ST_RUN;
			ocfr_pkg::ST_RUN:   if (pin.oc) begin
				if (resp.mode == ocfr_pkg::MODE_OFF) shut = 1'b1;
				else next_state = ocfr_pkg::ST_LIMIT;
			end
			ocfr_pkg::ST_LIMIT: begin
				if (!pin.oc) next_state = ocfr_pkg::ST_RUN;
				else if (resp.mode == ocfr_pkg::MODE_COND && pin.uv) shut = 1'b1;
				else if (resp.mode == ocfr_pkg::MODE_DELAY && tmr_done) shut = 1'b1;
				else if (resp.mode == ocfr_pkg::MODE_OFF) shut = 1'b1;
			end
			ocfr_pkg::ST_WAIT:  if (tmr_done) next_state = ocfr_pkg::ST_RUN;
			ocfr_pkg::ST_LATCH: if (clr_pulse) next_state = ocfr_pkg::ST_RUN;
		endcase
		// retries left restart after the delay, otherwise off until cleared
		if (shut) begin
			next_state = (resp.retry == ocfr_pkg::RETRY_FOREVER || attempts < resp.retry) ?
				ocfr_pkg::ST_WAIT : ocfr_pkg::ST_LATCH;
		end
		if (other_fault && state != ocfr_pkg::ST_OFF) next_state = ocfr_pkg::ST_LATCH;
		if (!pin.on) next_state = ocfr_pkg::ST_OFF;
	end

	assign tmr_start = (next_state == ocfr_pkg::ST_LIMIT && state != ocfr_pkg::ST_LIMIT) ||
		(next_state == ocfr_pkg::ST_WAIT && state != ocfr_pkg::ST_WAIT);
	// set wins over clear so a fault in the clearing cycle is kept;
	// commanding the output off clears the fault just as the clear command does
	assign next_status = oc_rise | (oc_status & ~clr_pulse & pin.on);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state     <= ocfr_pkg::ST_OFF;
			output_en <= 1'b0;
			cc_limit  <= 1'b0;
		end else begin
			state     <= next_state;
			output_en <= (next_state == ocfr_pkg::ST_RUN) || (next_state == ocfr_pkg::ST_LIMIT);
			cc_limit  <= (next_state == ocfr_pkg::ST_LIMIT);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			attempts <= 3'h0;
		end else if (!pin.on || clr_pulse) begin
			attempts <= 3'h0;
		end else if (tmr_start && next_state == ocfr_pkg::ST_WAIT && attempts != 3'h7) begin
			attempts <= attempts + 3'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			oc_status <= 1'b0;
			alert_n   <= 1'b1;
		end else begin
			oc_status <= next_status;
			alert_n   <= ~next_status;
		end
	end

	ocfr_delay_timer #(.UNIT_W(UNIT_W)) u_timer (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.start       (tmr_start),
		.exp_sel     (resp.delay),
		.unit_cycles (unit_cycles),
		.done        (tmr_done)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_oc_in_run;
		state == ocfr_pkg::ST_RUN && pin.oc && pin.on && !other_fault;
	endsequence

	property p_ignore_holds;
		@(posedge sys_clk) disable iff (rst)
		(state == ocfr_pkg::ST_LIMIT && resp.mode == ocfr_pkg::MODE_IGNORE && pin.oc &&
			pin.on && !other_fault) |=> (cc_limit && output_en);
	endproperty
	a_ignore_holds: assert property (p_ignore_holds)
		else $error("ignore mode left current limiting");

	property p_cond_limit;
		@(posedge sys_clk) disable iff (rst)
		(s_oc_in_run and (resp.mode == ocfr_pkg::MODE_COND)) |=> cc_limit;
	endproperty
	a_cond_limit: assert property (p_cond_limit)
		else $error("conditioned mode did not limit");

	property p_cond_shut;
		@(posedge sys_clk) disable iff (rst)
		(state == ocfr_pkg::ST_LIMIT && resp.mode == ocfr_pkg::MODE_COND && pin.oc && pin.uv)
			|=> !output_en;
	endproperty
	a_cond_shut: assert property (p_cond_shut)
		else $error("low output voltage did not shut down");

	property p_off_now;
		@(posedge sys_clk) disable iff (rst)
		(s_oc_in_run and (resp.mode == ocfr_pkg::MODE_OFF)) |=> !output_en ##1 !output_en;
	endproperty
	a_off_now: assert property (p_off_now)
		else $error("shutdown mode kept output on");

	property p_no_retry;
		@(posedge sys_clk) disable iff (rst)
		(shut && resp.retry == ocfr_pkg::RETRY_NONE && pin.on) |=> state == ocfr_pkg::ST_LATCH;
	endproperty
	a_no_retry: assert property (p_no_retry)
		else $error("retry zero restarted");

	property p_forever;
		@(posedge sys_clk) disable iff (rst)
		(shut && resp.retry == ocfr_pkg::RETRY_FOREVER && pin.on && !other_fault)
			|=> state == ocfr_pkg::ST_WAIT;
	endproperty
	a_forever: assert property (p_forever)
		else $error("continuous retry gave up");

	property p_latch_stays;
		@(posedge sys_clk) disable iff (rst)
		(state == ocfr_pkg::ST_LATCH && !clr_pulse && pin.on) |=> !output_en;
	endproperty
	a_latch_stays: assert property (p_latch_stays)
		else $error("output came back without clearing");

	property p_status_alert;
		@(posedge sys_clk) disable iff (rst)
		oc_rise |=> (oc_status && !alert_n);
	endproperty
	a_status_alert: assert property (p_status_alert)
		else $error("fault did not set status and alert");

	property p_attempt_reset;
		@(posedge sys_clk) disable iff (rst)
		(!pin.on || clr_pulse) |=> attempts == 3'h0;
	endproperty
	a_attempt_reset: assert property (p_attempt_reset)
		else $error("attempt counter not cleared");

	property p_limit_stable;
		@(posedge sys_clk) disable iff (rst)
		!wr_limit |=> $stable(oc_limit);
	endproperty
	a_limit_stable: assert property (p_limit_stable)
		else $error("limit changed without a write");
endmodule : ocfr_fault_ctrl
`default_nettype wire

// [pkg/ocfr_pkg.sv]
// shared constants and types of the over-current fault response block
package ocfr_pkg;
	localparam logic [7:0]  CMD_LIMIT     = 8'h46;
	localparam logic [7:0]  CMD_RESP      = 8'h47;
	localparam logic [7:0]  CMD_CLEAR     = 8'h03;
	localparam logic [7:0]  RD_IDLE_BYTE  = 8'hff;
	localparam logic [15:0] LIMIT_RST     = 16'h0000;
	localparam logic [7:0]  RESP_RST      = 8'hc0;
	localparam logic [1:0]  MODE_IGNORE   = 2'h0;
	localparam logic [1:0]  MODE_COND     = 2'h1;
	localparam logic [1:0]  MODE_DELAY    = 2'h2;
	localparam logic [1:0]  MODE_OFF      = 2'h3;
	localparam logic [2:0]  RETRY_NONE    = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER = 3'h7;
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [1:0]  NB_CMD_ONLY   = 2'h1;
	localparam logic [1:0]  NB_BYTE       = 2'h2;
	localparam logic [1:0]  NB_WORD       = 2'h3;
	localparam logic [6:0]  DEV_ADDR_DEF  = 7'h2a;

	// response byte layout: mode 7:6, retry 5:3, delay 2:0
	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] retry;
		logic [2:0] delay;
	} ocfr_resp_t;

	// synchronised pin levels
	typedef struct packed {
		logic on;
		logic uv;
		logic oc;
		logic sda;
		logic scl;
	} ocfr_pins_t;

	typedef enum logic [4:0] {
		ST_OFF   = 5'b00001,
		ST_RUN   = 5'b00010,
		ST_LIMIT = 5'b00100,
		ST_WAIT  = 5'b01000,
		ST_LATCH = 5'b10000
	} ocfr_state_t;

	typedef enum logic [6:0] {
		PH_IDLE = 7'b0000001,
		PH_ADDR = 7'b0000010,
		PH_AACK = 7'b0000100,
		PH_WR   = 7'b0001000,
		PH_WACK = 7'b0010000,
		PH_RD   = 7'b0100000,
		PH_RACK = 7'b1000000
	} ocfr_phase_t;
endpackage : ocfr_pkg
